// ### src/mdsc_pkg.sv
// Purpose: shared constants for the motor driver status/config register bank
// Assumes: 8-bit registers at byte offsets 6h..Dh, reached over the device register port
// Notes: offsets are register indices on the device's own register port
package mdsc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_REGULATED_DUTY_STATUS = 8'h06;
  localparam logic [7:0] OFS_SPARE_STATUS_A = 8'h07;
  localparam logic [7:0] OFS_SPARE_STATUS_B = 8'h08;
  localparam logic [7:0] OFS_FAULT_ENABLE_CONFIG = 8'h09;
  localparam logic [7:0] OFS_INRUSH_TIME_LOW = 8'h0A;
  localparam logic [7:0] OFS_INRUSH_TIME_HIGH = 8'h0B;
  localparam logic [7:0] OFS_MODE_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_REPORT_CONFIG = 8'h0D;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_FAULT_ENABLE_CONFIG = 8'h60;
  localparam logic [7:0] RST_INRUSH_TIME = 8'h00;
  localparam logic [7:0] RST_MODE_CONFIG = 8'h63;
  localparam logic [7:0] RST_REPORT_CONFIG = 8'h38;
  localparam logic [7:0] RST_STATUS = 8'h00;
  // ==========================================================
  // fault_enable_config field positions
  localparam int BIT_OUTPUT_ENABLE = 7;
  localparam int BIT_OVERVOLTAGE_PROTECT_ON = 6;
  localparam int BIT_STALL_ENABLE = 5;
  localparam int BIT_OUTPUT_VOLTAGE_SENSE_SELECT = 4;
  localparam int BIT_REGULATION_RANGE_SELECT = 3;
  localparam int BIT_FAULT_CLEAR_CMD = 1;
  localparam int BIT_MANUAL_DUTY_PERMIT = 0;
  // writable mask: bit 2 reserved, reads zero
  localparam logic [7:0] MASK_FAULT_ENABLE_CONFIG = 8'hFB;
  localparam int DUTY_WIDTH = 6;
  localparam int BLANK_WIDTH = 16;
endpackage : mdsc_pkg

// ### src/mdsc_blank_timer.sv
// Purpose: inrush blanking counter gating stall detection
// Assumes: motor_start is a one-cycle pulse at motor start
// Notes: count is in clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module mdsc_blank_timer
  import mdsc_pkg::*;
#(
  parameter int WIDTH = BLANK_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic motor_start,
  input wire logic [WIDTH-1:0] blank_count,
  output logic blanking
);
  if (WIDTH < 1) begin : g_width_check
    $error("mdsc_blank_timer: WIDTH must be positive");
  end

  logic [WIDTH-1:0] remain_r;

  // ==========================================================
  // countdown
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      remain_r <= '0;
    end else if (motor_start) begin
      // start cycle is the first blanked one, so load one less
      remain_r <= (blank_count == '0) ? '0 : blank_count - WIDTH'(1);
    end else if (remain_r != '0) begin
      remain_r <= remain_r - WIDTH'(1);
    end
  end

  // a stall seen in the start cycle itself must not latch either
  assign blanking = (remain_r != '0) || (motor_start && (blank_count != '0));
endmodule : mdsc_blank_timer
`default_nettype wire

// ### src/mdsc_voltage_sense.sv
// Purpose: output voltage estimate for voltage regulation
// Assumes: analog filter result and supply code are 8-bit codes
// Notes: digital path is duty times supply, divided by 64
`timescale 1ns/1ps
`default_nettype none
module mdsc_voltage_sense
  import mdsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sense_select,
  input wire logic range_select,
  input wire logic [DUTY_WIDTH-1:0] duty,
  input wire logic [7:0] motor_supply,
  input wire logic [7:0] analog_filter_volt,
  output logic [7:0] output_volt,
  output logic small_range
);
  logic [13:0] product;
  logic [7:0] digital_volt;

  assign product = 14'(duty) * 14'(motor_supply);
  // divide by 64 instead of 63: up to 4 codes of error at full duty, saves a divider
  assign digital_volt = product[13:6];

  // ==========================================================
  // select source
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_volt <= 8'h00;
      small_range <= 1'b0;
    end else begin
      output_volt <= sense_select ? digital_volt : analog_filter_volt;
      small_range <= range_select;
    end
  end
endmodule : mdsc_voltage_sense
`default_nettype wire

// ### src/mdsc_regs.sv
// Purpose: status and configuration register bank of a brushed DC motor driver
// Assumes: reg_* port is the device's register port after the serial bus decoder
// Notes: writes take effect at the edge where reg_wr is high; reads are registered
//
// Behaviour
// - duty readback in bits 5-0, upper reserved
// - duty code 000000b=0%, 111111b=100%
// - readback meaningful only under speed/voltage regulation
// - output enable bit 7 else bridge hi-z
// - overvoltage protect bit 6 on after reset
// - stall detection bit 5, on by reset
// - sense bit 4 zero: analog filter voltage
// - sense bit one: duty times supply voltage
// - bit 3 selects 16V or 4V range
// - fault clear bit 1 clears latched faults
// - fault clear bit self-clears
// - permission bit 0 zero: ignore manual duty
// - manual duty drives bridge without speed regulation
// - inrush low register holds low byte
// - no stall during inrush blanking
// - reset loads 60h, inrush and duty zero
// - inrush high register holds high byte
// - power-on flag latches high after clear
`timescale 1ns/1ps
`default_nettype none
module mdsc_regs
  import mdsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // manual duty write from host
  input wire logic manual_duty_wr,
  input wire logic [DUTY_WIDTH-1:0] manual_duty_value,
  // regulation core
  input wire logic speed_reg_active,
  input wire logic volt_reg_active,
  input wire logic [DUTY_WIDTH-1:0] regulation_duty,
  input wire logic motor_start,
  input wire logic stall_raw,
  input wire logic overvoltage_raw,
  input wire logic [7:0] motor_supply,
  input wire logic [7:0] analog_filter_volt,
  // bridge and protection
  output logic bridge_enable,
  output logic [DUTY_WIDTH-1:0] bridge_duty,
  output logic overvoltage_protect_on,
  output logic stall_detect_on,
  output logic stall_fault,
  output logic overvoltage_fault,
  output logic fault_clear_pulse,
  output logic power_on_flag,
  output logic [7:0] output_volt,
  output logic small_range,
  output logic [7:0] mode_config,
  output logic [7:0] report_config
);
  logic [7:0] fault_cfg_r;
  logic [7:0] inrush_low_r;
  logic [7:0] inrush_high_r;
  logic [7:0] mode_cfg_r;
  logic [7:0] report_cfg_r;
  logic [DUTY_WIDTH-1:0] duty_status_r;
  logic [DUTY_WIDTH-1:0] manual_duty_r;
  logic clear_r;
  logic power_on_r;
  logic stall_r;
  logic ovp_r;
  logic [7:0] rdata_nxt;
  logic blanking;
  logic regulating;
  logic wr_cfg;

  assign wr_cfg = reg_wr && (reg_addr == OFS_FAULT_ENABLE_CONFIG);
  assign regulating = speed_reg_active || volt_reg_active;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_cfg_r <= RST_FAULT_ENABLE_CONFIG;
      inrush_low_r <= RST_INRUSH_TIME;
      inrush_high_r <= RST_INRUSH_TIME;
      mode_cfg_r <= RST_MODE_CONFIG;
      report_cfg_r <= RST_REPORT_CONFIG;
    end else if (reg_wr) begin
      // unlisted offsets are dropped; host must not write them
      unique case (reg_addr)
        OFS_FAULT_ENABLE_CONFIG: begin
          // clear bit never stored, so it always reads back zero
          fault_cfg_r <= reg_wdata & MASK_FAULT_ENABLE_CONFIG
            & ~(8'h01 << BIT_FAULT_CLEAR_CMD);
        end
        OFS_INRUSH_TIME_LOW: inrush_low_r <= reg_wdata;
        OFS_INRUSH_TIME_HIGH: inrush_high_r <= reg_wdata;
        OFS_MODE_CONFIG: mode_cfg_r <= reg_wdata;
        OFS_REPORT_CONFIG: report_cfg_r <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // fault clear command, one-cycle pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clear_r <= 1'b0;
    end else begin
      clear_r <= wr_cfg && reg_wdata[BIT_FAULT_CLEAR_CMD];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_on_r <= 1'b0;
    end else if (clear_r) begin
      power_on_r <= 1'b1;
    end
  end

  // ==========================================================
  // latched faults; a new event in the clear cycle wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stall_r <= 1'b0;
      ovp_r <= 1'b0;
    end else begin
      if (stall_raw && fault_cfg_r[BIT_STALL_ENABLE] && !blanking) begin
        stall_r <= 1'b1;
      end else if (clear_r) begin
        stall_r <= 1'b0;
      end
      if (overvoltage_raw && fault_cfg_r[BIT_OVERVOLTAGE_PROTECT_ON]) begin
        ovp_r <= 1'b1;
      end else if (clear_r) begin
        ovp_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // manual duty and duty readback
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      manual_duty_r <= '0;
    end else if (manual_duty_wr && fault_cfg_r[BIT_MANUAL_DUTY_PERMIT]) begin
      manual_duty_r <= manual_duty_value;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      duty_status_r <= '0;
    end else if (regulating) begin
      // outside regulation the last value is held, with no defined meaning
      duty_status_r <= regulation_duty;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bridge_duty <= '0;
    end else if (!speed_reg_active && fault_cfg_r[BIT_MANUAL_DUTY_PERMIT]) begin
      bridge_duty <= manual_duty_r;
    end else begin
      bridge_duty <= regulation_duty;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      OFS_REGULATED_DUTY_STATUS: rdata_nxt = {2'b00, duty_status_r};
      OFS_SPARE_STATUS_A: rdata_nxt = RST_STATUS;
      OFS_SPARE_STATUS_B: rdata_nxt = RST_STATUS;
      OFS_FAULT_ENABLE_CONFIG: rdata_nxt = fault_cfg_r;
      OFS_INRUSH_TIME_LOW: rdata_nxt = inrush_low_r;
      OFS_INRUSH_TIME_HIGH: rdata_nxt = inrush_high_r;
      OFS_MODE_CONFIG: rdata_nxt = mode_cfg_r;
      OFS_REPORT_CONFIG: rdata_nxt = report_cfg_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // sub-blocks
  mdsc_blank_timer #(
    .WIDTH(BLANK_WIDTH)
  ) u_blank (
    .clk_sys(clk_sys),
    .rst(rst),
    .motor_start(motor_start),
    .blank_count({inrush_high_r, inrush_low_r}),
    .blanking(blanking)
  );

  mdsc_voltage_sense u_vsense (
    .clk_sys(clk_sys),
    .rst(rst),
    .sense_select(fault_cfg_r[BIT_OUTPUT_VOLTAGE_SENSE_SELECT]),
    .range_select(fault_cfg_r[BIT_REGULATION_RANGE_SELECT]),
    .duty(bridge_duty),
    .motor_supply(motor_supply),
    .analog_filter_volt(analog_filter_volt),
    .output_volt(output_volt),
    .small_range(small_range)
  );

  assign bridge_enable = fault_cfg_r[BIT_OUTPUT_ENABLE];
  assign overvoltage_protect_on = fault_cfg_r[BIT_OVERVOLTAGE_PROTECT_ON];
  assign stall_detect_on = fault_cfg_r[BIT_STALL_ENABLE] && !blanking;
  assign stall_fault = stall_r;
  assign overvoltage_fault = ovp_r;
  assign fault_clear_pulse = clear_r;
  assign power_on_flag = power_on_r;
  assign mode_config = mode_cfg_r;
  assign report_config = report_cfg_r;
endmodule : mdsc_regs
`default_nettype wire

// ### dv/mdsc_host_model.sv
// Purpose: host side of the register port, issues reads and writes
// Assumes: requests change at the falling edge, taken at the next rising edge
// Notes: write data is scrambled after each write so stale data is never reused
`timescale 1ns/1ps
`default_nettype none
module mdsc_host_model
  import mdsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // ==========================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    // answer stands one cycle only
    d = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : mdsc_host_model
`default_nettype wire

// ### dv/mdsc_regs_asserts.sv
// Purpose: port checker for the register bank
// Assumes: one clock domain, rst asynchronous active high
// Notes: bound into every register bank instance
`timescale 1ns/1ps
`default_nettype none
module mdsc_regs_chk
  import mdsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic bridge_enable,
  input wire logic overvoltage_protect_on,
  input wire logic stall_detect_on,
  input wire logic fault_clear_pulse,
  input wire logic power_on_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == OFS_FAULT_ENABLE_CONFIG;
  // ==========================================================
  // assertions
  AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  AST_DUTY_UPPER: assert property (reg_rd && reg_addr == OFS_REGULATED_DUTY_STATUS
    |=> reg_rdata[7:6] == 2'h0) else $error("duty readback upper bits set");
  AST_SPARE_ZERO: assert property (reg_rd && (reg_addr == OFS_SPARE_STATUS_A ||
    reg_addr == OFS_SPARE_STATUS_B) |=> reg_rdata == 8'h00) else $error("spare not zero");
  AST_CFG_RSVD: assert property (reg_rd && reg_addr == OFS_FAULT_ENABLE_CONFIG
    |=> reg_rdata[2:1] == 2'h0) else $error("config bits 2..1 read nonzero");
  AST_OUT_EN: assert property (cfg_wr |=> bridge_enable == $past(reg_wdata[7]))
    else $error("output enable does not follow write");
  AST_OVP_EN: assert property (cfg_wr |=> overvoltage_protect_on == $past(reg_wdata[6]))
    else $error("overvoltage enable does not follow write");
  AST_STALL_OFF: assert property (cfg_wr && !reg_wdata[5] |=> !stall_detect_on)
    else $error("stall detection still on");
  AST_CLR_PULSE: assert property (cfg_wr && reg_wdata[1] |=> fault_clear_pulse)
    else $error("fault clear pulse missing");
  AST_POR_SET: assert property (fault_clear_pulse |=> power_on_flag)
    else $error("power on flag not set");
  AST_POR_STICKY: assert property (power_on_flag |=> power_on_flag)
    else $error("power on flag dropped");
endmodule : mdsc_regs_chk
bind mdsc_regs mdsc_regs_chk u_chk (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .reg_rvalid, .bridge_enable, .overvoltage_protect_on,
  .stall_detect_on, .fault_clear_pulse, .power_on_flag);
`default_nettype wire

// ### dv/mdsc_regs_tb_top.sv
// Purpose: self-checking bench for the register bank
// Assumes: inputs change at the falling edge
// Notes: random values come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module mdsc_regs_tb_top
  import mdsc_pkg::*;
;
  logic clk_sys, rst, manual_duty_wr, speed_reg_active, volt_reg_active, motor_start;
  logic stall_raw, overvoltage_raw, reg_wr, reg_rd, reg_rvalid, bridge_enable;
  logic overvoltage_protect_on, stall_detect_on, stall_fault, overvoltage_fault;
  logic fault_clear_pulse, power_on_flag, small_range;
  logic [5:0] manual_duty_value, regulation_duty, bridge_duty;
  logic [7:0] motor_supply, analog_filter_volt, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] output_volt, mode_config, report_config, d, v;
  int n_fail = 0;
  int check_count = 0;
  mdsc_host_model u_mdsc_host_model (.clk_sys, .reg_rdata, .reg_rvalid, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata);
  mdsc_regs u_mdsc_regs (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .manual_duty_wr, .manual_duty_value, .speed_reg_active,
    .volt_reg_active, .regulation_duty, .motor_start, .stall_raw, .overvoltage_raw,
    .motor_supply, .analog_filter_volt, .bridge_enable, .bridge_duty,
    .overvoltage_protect_on, .stall_detect_on, .stall_fault, .overvoltage_fault,
    .fault_clear_pulse, .power_on_flag, .output_volt, .small_range, .mode_config,
    .report_config);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_mdsc_host_model.rd(a, r);
    chk($sformatf("reg %h", a), r, exp);
  endtask : rdchk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // digital sense: duty times supply, full scale taken as 64 codes
  function automatic logic [7:0] exp_volt(input logic [5:0] dd, input logic [7:0] s);
    logic [13:0] p;
    p = 14'(dd) * 14'(s);
    return p[13:6];
  endfunction : exp_volt
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    u_mdsc_host_model.wr(a, x);
  endtask : wr
  task automatic mduty(input logic [5:0] x);
    manual_duty_value = x;
    manual_duty_wr = 1'b1;
    cyc(1);
    manual_duty_wr = 1'b0;
    cyc(2);
  endtask : mduty
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
  // ==========================================================
  // tests
  initial begin
    logic [7:0] exp_rst [8];
    exp_rst = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h63, 8'h38};
    {manual_duty_wr, speed_reg_active, volt_reg_active, motor_start} = 4'h0;
    {stall_raw, overvoltage_raw} = 2'h0;
    manual_duty_value = 6'h00;
    regulation_duty = 6'h00;
    motor_supply = 8'h80;
    analog_filter_volt = 8'h5A;
    rst = 1'b1;
    void'($urandom(32'h7DBA103E));
    cyc(16);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rdchk(8'h06 + i[7:0], exp_rst[i]);
    v = {5'h00, bridge_enable, overvoltage_protect_on, stall_detect_on};
    chk("outputs after reset", v, 8'h03);
    chk("mode_config", mode_config, RST_MODE_CONFIG);
    chk("report_config", report_config, RST_REPORT_CONFIG);
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h00);
    wr(OFS_SPARE_STATUS_A, 8'hFF);
    rdchk(OFS_SPARE_STATUS_A, 8'h00);
    $display("test reset_and_map done");
    for (int i = 0; i < 10; i++) begin
      v = i == 0 ? 8'h00 : i == 1 ? 8'hFD : 8'($urandom) & 8'hFD;
      wr(OFS_FAULT_ENABLE_CONFIG, v);
      cyc(2);
      rdchk(OFS_FAULT_ENABLE_CONFIG, v & MASK_FAULT_ENABLE_CONFIG);
      chk("bridge_enable", bridge_enable, v[7]);
      chk("overvoltage_protect_on", overvoltage_protect_on, v[6]);
      chk("stall_detect_on", stall_detect_on, v[5]);
      chk("small_range", small_range, v[3]);
      if (!v[4]) chk("output_volt", output_volt, analog_filter_volt);
    end
    $display("test config done");
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h20);
    overvoltage_raw = 1'b1;
    cyc(3);
    chk("overvoltage_fault", overvoltage_fault, 1'b0);
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h60);
    cyc(3);
    overvoltage_raw = 1'b0;
    chk("overvoltage_fault", overvoltage_fault, 1'b1);
    chk("power_on_flag", power_on_flag, 1'b0);
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h62);
    chk("fault_clear_pulse", fault_clear_pulse, 1'b1);
    cyc(1);
    chk("fault_clear_pulse", fault_clear_pulse, 1'b0);
    chk("overvoltage_fault", overvoltage_fault, 1'b0);
    chk("power_on_flag", power_on_flag, 1'b1);
    rdchk(OFS_FAULT_ENABLE_CONFIG, 8'h60);
    $display("test fault_clear done");
    speed_reg_active = 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = i == 0 ? 8'h00 : i == 1 ? 8'h3F : 8'($urandom) & 8'h3F;
      regulation_duty = d[5:0];
      cyc(3);
      rdchk(OFS_REGULATED_DUTY_STATUS, d);
    end
    speed_reg_active = 1'b0;
    cyc(1);
    regulation_duty = ~d[5:0];
    cyc(3);
    rdchk(OFS_REGULATED_DUTY_STATUS, d);
    $display("test duty_readback done");
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h61);
    d = 8'($urandom) & 8'h3F;
    mduty(d[5:0]);
    chk("bridge_duty", bridge_duty, d);
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h60);
    mduty(~d[5:0]);
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h71);
    motor_supply = 8'($urandom);
    cyc(3);
    chk("bridge_duty", bridge_duty, d);
    chk("output_volt", output_volt, exp_volt(d[5:0], motor_supply));
    $display("test manual_duty done");
    v = 8'($urandom);
    wr(OFS_INRUSH_TIME_LOW, v);
    wr(OFS_INRUSH_TIME_HIGH, ~v);
    rdchk(OFS_INRUSH_TIME_LOW, v);
    rdchk(OFS_INRUSH_TIME_HIGH, ~v);
    // blanking 0104h = 260 cycles, the start cycle counted as the first
    wr(OFS_INRUSH_TIME_LOW, 8'h04);
    wr(OFS_INRUSH_TIME_HIGH, 8'h01);
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h60);
    motor_start = 1'b1;
    stall_raw = 1'b1;
    cyc(1);
    motor_start = 1'b0;
    cyc(200);
    chk("stall_detect_on", stall_detect_on, 1'b0);
    chk("stall_fault", stall_fault, 1'b0);
    cyc(58);
    chk("stall_detect_on", stall_detect_on, 1'b0);
    cyc(1);
    chk("stall_detect_on", stall_detect_on, 1'b1);
    chk("stall_fault", stall_fault, 1'b0);
    cyc(1);
    chk("stall_fault", stall_fault, 1'b1);
    stall_raw = 1'b0;
    wr(OFS_FAULT_ENABLE_CONFIG, 8'h62);
    cyc(1);
    chk("stall_fault", stall_fault, 1'b0);
    $display("test inrush done");
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rdchk(OFS_FAULT_ENABLE_CONFIG, 8'h60);
    chk("power_on_flag", power_on_flag, 1'b0);
    $display("test second_reset done");
    summarize();
  end
endmodule : mdsc_regs_tb_top
`default_nettype wire
